//--- cps_pkg.sv
`default_nettype none

package cps_pkg;

	// Register byte addresses
	localparam logic [7:0] ADDR_STATUS = 8'h44;
	localparam logic [7:0] ADDR_IR   = 8'h50;
	localparam logic [7:0] ADDR_IE   = 8'h54;

	// Field positions as printed, most significant bit numbered 0
	localparam int MSB0_TOP   = 31;
	localparam int MSB0_FD_SEEN  = 18;
	localparam int MSB0_RBRS     = 19;
	localparam int MSB0_ESI      = 20;
	localparam int MSB0_FAST     = 23;
	localparam int MSB0_BUS_OFF  = 24;
	localparam int MSB0_WARN     = 25;
	localparam int MSB0_PASSIVE  = 26;
	localparam int MSB0_ACTIVITY = 28;
	localparam int MSB0_NOM      = 31;

	// Same fields as ordinary bit indices (low bit of each field)
	localparam int POS_FD_SEEN   = MSB0_TOP - MSB0_FD_SEEN;
	localparam int POS_RBRS      = MSB0_TOP - MSB0_RBRS;
	localparam int POS_ESI       = MSB0_TOP - MSB0_ESI;
	localparam int POS_FAST      = MSB0_TOP - MSB0_FAST;
	localparam int POS_BUS_OFF   = MSB0_TOP - MSB0_BUS_OFF;
	localparam int POS_WARN      = MSB0_TOP - MSB0_WARN;
	localparam int POS_PASSIVE   = MSB0_TOP - MSB0_PASSIVE;
	localparam int POS_ACTIVITY  = MSB0_TOP - MSB0_ACTIVITY;
	localparam int POS_NOM       = MSB0_TOP - MSB0_NOM;

	// Error code encoding
	localparam logic [2:0] CODE_NONE   = 3'h0;
	localparam logic [2:0] CODE_STUFF  = 3'h1;
	localparam logic [2:0] CODE_FORM   = 3'h2;
	localparam logic [2:0] CODE_ACK    = 3'h3;
	localparam logic [2:0] CODE_BIT1   = 3'h4;
	localparam logic [2:0] CODE_BIT0   = 3'h5;
	localparam logic [2:0] CODE_CRC    = 3'h6;
	localparam logic [2:0] CODE_NOCHG  = 3'h7;
	localparam logic [2:0] CODE_RESET  = CODE_NOCHG;

	// Error counter thresholds
	localparam int WARN_LIMIT    = 96;
	localparam int PASSIVE_LIMIT = 128;

	typedef enum logic [1:0] {
		NODE_SYNC = 2'h0,
		NODE_IDLE = 2'h1,
		NODE_RX   = 2'h2,
		NODE_TX   = 2'h3
	} cps_activity_t;

	// Interrupt status / mask bit positions
	localparam int IRQ_FD    = 0;
	localparam int IRQ_FAST  = 1;
	localparam int IRQ_NOM   = 2;
	localparam int IRQ_BUS_OFF = 3;
	localparam int IRQ_WARN    = 4;
	localparam int IRQ_PASSIVE = 5;
	localparam int IRQ_W     = 6;
	localparam logic [5:0] IR_RESET = 6'h00;
	localparam logic [5:0] IE_RESET = 6'h00;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [0:0] {
		WS_COLLECT = 1'h0,
		WS_RESP    = 1'h1
	} cps_wstate_t;

endpackage : cps_pkg

`default_nettype wire

//--- cps_code_if.sv
`timescale 1ns/10ps
`default_nettype none

interface cps_code_if;
	logic       ev;
	logic [2:0] ev_code;
	logic       ok;
	logic       rd;
	logic [2:0] code;

	modport source (
		output ev,
		output ev_code,
		output ok,
		output rd,
		input  code
	);

	modport field (
		input  ev,
		input  ev_code,
		input  ok,
		input  rd,
		output code
	);
endinterface : cps_code_if

`default_nettype wire

//--- cps_err_code.sv
`timescale 1ns/10ps
`default_nettype none

module cps_err_code (
	input wire logic   aclk,
	input wire logic   aresetn,
	cps_code_if.field  fld
);

	typedef struct packed {
		logic [2:0] code;
	} cps_code_state_t;

	cps_code_state_t st;
	cps_code_state_t next_st;

	// Event beats read, read beats nothing
	always_comb begin
		next_st = st;
		if (fld.ev) begin
			next_st.code = fld.ev_code;
		end else if (fld.ok) begin
			next_st.code = cps_pkg::CODE_NONE;
		end else if (fld.rd) begin
			next_st.code = cps_pkg::CODE_NOCHG;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st.code <= cps_pkg::CODE_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign fld.code = st.code;

endmodule : cps_err_code

`default_nettype wire

//--- cps_status.sv
// Function
// - Capture ESI with each received FD frame
// - Status read clears captured ESI flag
// - Data-phase error code holds last fast error
// - Error-free BRS frame zeroes data-phase code
// - Status read loads data-phase code no-change value
// - No-change value is seven
// - Error codes use the shared three-bit encoding
// - Event after BRS data phase goes fast
// - Bit 24 shows bus-off state
// - Bit 25 shows a counter reached 96
// - Bit 26 shows error-passive state
// - Two-bit field shows node activity
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/10ps
`default_nettype none

module cps_status #(
	parameter int ADDR_W = 8,
	parameter int CNT_W  = 8
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output var  logic              s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output var  logic              s_axi_wready,
	output var  logic [1:0]        s_axi_bresp,
	output var  logic              s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output var  logic              s_axi_arready,
	output var  logic [31:0]       s_axi_rdata,
	output var  logic [1:0]        s_axi_rresp,
	output var  logic              s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              core_fd_rx,
	input  wire logic              core_fd_esi,
	input  wire logic              core_fd_brs,
	input  wire logic              core_data_phase,
	input  wire logic              core_err,
	input  wire logic [2:0]        core_err_code,
	input  wire logic              core_frame_ok,
	input  wire logic              core_bus_off,
	input  wire logic [CNT_W-1:0]  core_tec,
	input  wire logic [CNT_W-1:0]  core_rec,
	input  wire logic [1:0]        core_activity,
	output var  logic              irq
);

	if (ADDR_W < 8 || ADDR_W > 32) begin : g_addr_check
		$error("ADDR_W must lie between 8 and 32");
	end
	if (CNT_W < 8) begin : g_cnt_check
		$error("CNT_W must be at least 8 to reach the passive limit");
	end

	typedef struct packed {
		cps_pkg::cps_wstate_t  wstate;
		logic                  aw_got;
		logic                  w_got;
		logic [ADDR_W-1:0]     awaddr;
		logic [31:0]           wdata;
		logic [3:0]            wstrb;
		logic                  awready;
		logic                  wready;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  arready;
		logic                  rvalid;
		logic [31:0]           rdata;
		logic [1:0]            rresp;
		logic                   fd_frame_received;
		logic                   rbrs;
		logic                   fd_esi_seen;
		logic                   fast_armed;
		logic                   bus_off_flag;
		logic                   error_warning_flag;
		logic                   error_passive_flag;
		cps_pkg::cps_activity_t node_activity_state;
		logic [5:0]            ir;
		logic [5:0]            ie;
		logic                  irq;
	} cps_state_t;

	localparam logic [CNT_W-1:0] WARN_CNT    = CNT_W'(cps_pkg::WARN_LIMIT);
	localparam logic [CNT_W-1:0] PASSIVE_CNT = CNT_W'(cps_pkg::PASSIVE_LIMIT);
	localparam logic [ADDR_W-1:0] A_STATUS   = ADDR_W'(cps_pkg::ADDR_STATUS);
	localparam logic [ADDR_W-1:0] A_IR       = ADDR_W'(cps_pkg::ADDR_IR);
	localparam logic [ADDR_W-1:0] A_IE       = ADDR_W'(cps_pkg::ADDR_IE);

	cps_state_t st;
	cps_state_t next_st;

	cps_code_if nom_if ();
	cps_code_if fast_if ();

	logic              aw_hs;
	logic              w_hs;
	logic              b_hs;
	logic              ar_hs;
	logic              r_hs;
	logic [ADDR_W-1:0] rd_addr;
	logic [ADDR_W-1:0] wr_addr;
	logic              status_rd;
	logic              route_fast;
	logic [31:0]       status_word;
	logic [31:0]       lane_mask;
	logic [5:0]        ev;
	logic [5:0]        w1c;

	assign aw_hs   = s_axi_awvalid & st.awready;
	assign w_hs    = s_axi_wvalid & st.wready;
	assign b_hs    = st.bvalid & s_axi_bready;
	assign ar_hs   = s_axi_arvalid & st.arready;
	assign r_hs    = st.rvalid & s_axi_rready;
	assign rd_addr = {s_axi_araddr[ADDR_W-1:2], 2'h0};
	assign wr_addr = {st.awaddr[ADDR_W-1:2], 2'h0};

	// Only a taken read of the status word has side effects
	// A read still waiting for arready must not clear anything
	assign status_rd = ar_hs & (rd_addr == A_STATUS);

	// Armed once a BRS frame entered its data phase
	// Data phase and event in one cycle still count as fast
	assign route_fast = st.fast_armed | core_data_phase;

	// Nominal code sees every event the fast code does not
	assign nom_if.ev       = core_err & ~route_fast;
	assign nom_if.ev_code  = core_err_code;
	assign nom_if.ok       = core_frame_ok & ~route_fast;
	assign nom_if.rd       = status_rd;
	// Data-phase code takes the rest, same encoding
	assign fast_if.ev      = core_err & route_fast;
	assign fast_if.ev_code = core_err_code;
	assign fast_if.ok      = core_frame_ok & route_fast;
	assign fast_if.rd      = status_rd;

	// One code field per phase, identical logic
	cps_err_code u_nom_code (
		.aclk    (aclk),
		.aresetn (aresetn),
		.fld     (nom_if.field)
	);

	cps_err_code u_fast_code (
		.aclk    (aclk),
		.aresetn (aresetn),
		.fld     (fast_if.field)
	);

	// Status word as software sees it
	always_comb begin
		status_word = 32'h0000_0000;

		// Reception flags of the last FD frame
		status_word[cps_pkg::POS_FD_SEEN] = st.fd_frame_received;
		status_word[cps_pkg::POS_RBRS] = st.rbrs;
		status_word[cps_pkg::POS_ESI] = st.fd_esi_seen;

		// Data-phase code, loaded with seven by a read
		status_word[cps_pkg::POS_FAST +: 3] = fast_if.code;

		// Node state, mirrored from the core
		status_word[cps_pkg::POS_BUS_OFF] = st.bus_off_flag;
		status_word[cps_pkg::POS_WARN] = st.error_warning_flag;
		status_word[cps_pkg::POS_PASSIVE] = st.error_passive_flag;
		status_word[cps_pkg::POS_ACTIVITY +: 2] = st.node_activity_state;

		// Nominal code shares the read behaviour
		status_word[cps_pkg::POS_NOM +: 3] = nom_if.code;
	end

	always_comb begin
		lane_mask = {{8{st.wstrb[3]}}, {8{st.wstrb[2]}}, {8{st.wstrb[1]}}, {8{st.wstrb[0]}}};
	end

	always_comb begin
		next_st = st;
		ev = 6'h00;
		w1c = 6'h00;

		// Node state mirrors, read-only from the bus
		// Refreshed every cycle, so no bus write can stick
		next_st.bus_off_flag = core_bus_off;
		next_st.error_warning_flag = (core_tec >= WARN_CNT) || (core_rec >= WARN_CNT);
		next_st.error_passive_flag = (core_tec >= PASSIVE_CNT) || (core_rec >= PASSIVE_CNT);
		next_st.node_activity_state = cps_pkg::cps_activity_t'(core_activity);

		// FD reception flags: read clears, new frame wins
		// Clear first, so a frame in the read cycle survives
		if (status_rd) begin
			next_st.fd_frame_received = 1'b0;
			next_st.rbrs = 1'b0;
			next_st.fd_esi_seen = 1'b0;
		end
		// Set regardless of acceptance filtering
		if (core_fd_rx) begin
			next_st.fd_frame_received = 1'b1;
			next_st.rbrs = core_fd_brs;
			next_st.fd_esi_seen = core_fd_esi;
		end

		// Data-phase arming ends with the next bus event
		if (core_err || core_frame_ok) begin
			next_st.fast_armed = 1'b0;
		end else if (core_data_phase) begin
			next_st.fast_armed = 1'b1;
		end

		// Interrupt events
		ev[cps_pkg::IRQ_FD] = core_fd_rx;
		ev[cps_pkg::IRQ_FAST] = core_err & route_fast;
		ev[cps_pkg::IRQ_NOM] = core_err & ~route_fast;
		// State bits raise an event on their rising edge only
		ev[cps_pkg::IRQ_BUS_OFF] = next_st.bus_off_flag & ~st.bus_off_flag;
		ev[cps_pkg::IRQ_WARN] = next_st.error_warning_flag & ~st.error_warning_flag;
		ev[cps_pkg::IRQ_PASSIVE] = next_st.error_passive_flag & ~st.error_passive_flag;

		// Write address channel
		if (aw_hs) begin
			next_st.aw_got = 1'b1;
			next_st.awaddr = s_axi_awaddr;
		end

		// Write data channel
		if (w_hs) begin
			next_st.w_got = 1'b1;
			next_st.wdata = s_axi_wdata;
			next_st.wstrb = s_axi_wstrb;
		end

		case (st.wstate)
			cps_pkg::WS_COLLECT: begin
				if (st.aw_got && st.w_got) begin
					next_st.aw_got = 1'b0;
					next_st.w_got = 1'b0;
					next_st.bvalid = 1'b1;
					next_st.bresp = cps_pkg::RESP_OKAY;
					next_st.wstate = cps_pkg::WS_RESP;
					if (wr_addr == A_IR) begin
						w1c = st.wdata[5:0] & lane_mask[5:0];
					end else if (wr_addr == A_IE) begin
						next_st.ie = (st.ie & ~lane_mask[5:0]) | (st.wdata[5:0] & lane_mask[5:0]);
					end else if (wr_addr != A_STATUS) begin
						// Status word writes end OKAY and change nothing
						next_st.bresp = cps_pkg::RESP_SLVERR;
					end
				end
			end
			cps_pkg::WS_RESP: begin
				if (b_hs) begin
					next_st.bvalid = 1'b0;
					next_st.wstate = cps_pkg::WS_COLLECT;
				end
			end
			default: begin
				next_st.wstate = cps_pkg::WS_COLLECT;
				next_st.bvalid = 1'b0;
			end
		endcase

		// Sticky status: a new event beats a same-cycle clear
		next_st.ir = (st.ir & ~w1c) | ev;

		// Read channel
		// Data captured at the take and held until rready
		if (ar_hs) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = cps_pkg::RESP_OKAY;
			if (rd_addr == A_STATUS) begin
				next_st.rdata = status_word;
			end else if (rd_addr == A_IR) begin
				next_st.rdata = {26'h0, st.ir};
			end else if (rd_addr == A_IE) begin
				next_st.rdata = {26'h0, st.ie};
			end else begin
				next_st.rdata = 32'h0000_0000;
				next_st.rresp = cps_pkg::RESP_SLVERR;
			end
		end else if (r_hs) begin
			next_st.rvalid = 1'b0;
		end

		// Ready flags: one transfer per channel at a time
		next_st.awready = !next_st.aw_got && (next_st.wstate == cps_pkg::WS_COLLECT);
		next_st.wready = !next_st.w_got && (next_st.wstate == cps_pkg::WS_COLLECT);
		next_st.arready = !next_st.rvalid;

		next_st.irq = |(next_st.ir & next_st.ie);
	end

	// Synchronous reset clears the whole state word
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Every output straight from a register
	assign s_axi_awready = st.awready;
	assign s_axi_wready  = st.wready;
	assign s_axi_bvalid  = st.bvalid;
	assign s_axi_bresp   = st.bresp;
	assign s_axi_arready = st.arready;
	assign s_axi_rvalid  = st.rvalid;
	assign s_axi_rdata   = st.rdata;
	assign s_axi_rresp   = st.rresp;
	assign irq           = st.irq;

endmodule : cps_status

`default_nettype wire

//--- cps_status_assertions.sv
`timescale 1ns/10ps
`default_nettype none

module cps_status_assertions #(
	parameter int ADDR_W = 8,
	parameter int CNT_W  = 8
) (
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic              s_axi_bvalid,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic [1:0]        s_axi_rresp,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	input wire logic              core_fd_rx,
	input wire logic              core_data_phase,
	input wire logic              core_err,
	input wire logic              core_frame_ok,
	input wire logic              core_bus_off,
	input wire logic [CNT_W-1:0]  core_tec,
	input wire logic [CNT_W-1:0]  core_rec,
	input wire logic [1:0]        core_activity
);
	logic ar_take;
	logic stat_rd;
	logic ev;
	logic clean;
	assign ar_take = s_axi_arvalid && s_axi_arready;
	assign stat_rd = ar_take && s_axi_araddr == ADDR_W'(cps_pkg::ADDR_STATUS);
	assign ev      = core_fd_rx || core_data_phase || core_err || core_frame_ok;
	// Status read seen with no bus event since
	always_ff @(posedge aclk) begin
		if (!aresetn || ev) begin
			clean <= 1'b0;
		end else if (stat_rd) begin
			clean <= 1'b1;
		end
	end
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_read_answer: assert property (ar_take |=> s_axi_rvalid) else $error("read not answered");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[2:3] s_axi_bvalid) else $error("write not answered");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_bus_off_mirror: assert property (stat_rd && $stable(core_bus_off)
		|=> s_axi_rdata[cps_pkg::POS_BUS_OFF] == $past(core_bus_off)) else $error("bus off bit wrong");
	a_warn_mirror: assert property (stat_rd && $stable(core_tec) && $stable(core_rec) |=>
		s_axi_rdata[cps_pkg::POS_WARN] == ($past(core_tec) >= 96 || $past(core_rec) >= 96))
		else $error("warning bit wrong");
	a_passive_mirror: assert property (stat_rd && $stable(core_tec) && $stable(core_rec) |=>
		s_axi_rdata[cps_pkg::POS_PASSIVE] == ($past(core_tec) >= 128 || $past(core_rec) >= 128))
		else $error("passive bit wrong");
	a_activity_mirror: assert property (stat_rd && $stable(core_activity)
		|=> s_axi_rdata[cps_pkg::POS_ACTIVITY +: 2] == $past(core_activity)) else $error("activity wrong");
	a_read_clears: assert property (stat_rd && clean && !ev |=> !s_axi_rdata[cps_pkg::POS_ESI] &&
		s_axi_rdata[cps_pkg::POS_FAST +: 3] == 3'h7) else $error("read did not reset fields");
	a_unmapped_err: assert property (ar_take && !(s_axi_araddr inside {8'h44, 8'h50, 8'h54})
		|=> s_axi_rresp == cps_pkg::RESP_SLVERR) else $error("unmapped read not refused");
endmodule : cps_status_assertions

bind cps_status cps_status_assertions #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) cps_status_assertions_i (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .core_fd_rx, .core_data_phase, .core_err, .core_frame_ok, .core_bus_off,
	.core_tec, .core_rec, .core_activity
);

`default_nettype wire

//--- cps_can_side.sv
`timescale 1ns/10ps
`default_nettype none

module cps_can_side (
	input  wire logic       aclk,
	output var  logic       core_fd_rx,
	output var  logic       core_fd_esi,
	output var  logic       core_fd_brs,
	output var  logic       core_data_phase,
	output var  logic       core_err,
	output var  logic [2:0] core_err_code,
	output var  logic       core_frame_ok,
	output var  logic       core_bus_off,
	output var  logic [7:0] core_tec,
	output var  logic [7:0] core_rec,
	output var  logic [1:0] core_activity
);
	initial begin
		{core_fd_rx, core_fd_esi, core_fd_brs, core_data_phase, core_err, core_frame_ok} = '0;
		{core_err_code, core_bus_off, core_tec, core_rec, core_activity} = '0;
	end
	// Frame bits flip to their inverse after the pulse
	task frame(input logic esi, input logic brs);
		@(posedge aclk);
		core_fd_rx <= 1'b1;
		core_fd_esi <= esi;
		core_fd_brs <= brs;
		@(posedge aclk);
		core_fd_rx <= 1'b0;
		core_fd_esi <= ~esi;
		core_fd_brs <= ~brs;
	endtask : frame
	task bus_event(input logic fast, input logic is_err, input logic [2:0] code);
		@(posedge aclk);
		core_data_phase <= fast;
		@(posedge aclk);
		core_data_phase <= 1'b0;
		core_err <= is_err;
		core_frame_ok <= !is_err;
		core_err_code <= code;
		@(posedge aclk);
		core_err <= 1'b0;
		core_frame_ok <= 1'b0;
		core_err_code <= ~code;
	endtask : bus_event
	task set_state(input logic bo, input logic [7:0] t, input logic [7:0] r, input logic [1:0] a);
		@(posedge aclk);
		core_bus_off <= bo;
		core_tec <= t;
		core_rec <= r;
		core_activity <= a;
	endtask : set_state
endmodule : cps_can_side

`default_nettype wire

//--- cps_status_tb.sv
`timescale 1ns/10ps
`default_nettype none

module cps_status_tb;
	localparam logic [7:0] STW = cps_pkg::ADDR_STATUS;
	localparam logic [7:0] IR  = cps_pkg::ADDR_IR;
	localparam logic [7:0] IE  = cps_pkg::ADDR_IE;
	localparam logic [2:0] NC  = cps_pkg::CODE_NOCHG;
	localparam logic [1:0] OK  = cps_pkg::RESP_OKAY;
	logic        aclk, aresetn, irq;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [2:0]  s_axi_awprot, s_axi_arprot, core_err_code;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd, e;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs, core_activity;
	logic        core_fd_rx, core_fd_esi, core_fd_brs, core_data_phase, core_err, core_frame_ok, core_bus_off;
	logic [7:0]  core_tec, core_rec;
	logic [7:0]  tecs [6] = '{8'h5F, 8'h60, 8'h00, 8'h7F, 8'h80, 8'h00};
	logic [7:0]  recs [6] = '{8'h00, 8'h00, 8'h60, 8'h5F, 8'h00, 8'h80};
	int          failures = 0;
	int          cmp_count = 0;

	cps_status cps_status_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .core_fd_rx, .core_fd_esi, .core_fd_brs, .core_data_phase, .core_err,
		.core_err_code, .core_frame_ok, .core_bus_off, .core_tec, .core_rec, .core_activity, .irq);
	cps_can_side cps_can_side_i (.aclk, .core_fd_rx, .core_fd_esi, .core_fd_brs, .core_data_phase,
		.core_err, .core_err_code, .core_frame_ok, .core_bus_off, .core_tec, .core_rec, .core_activity);

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	task tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : tally_and_finish
	task lost();
		failures++;
		$display("wrong value at %0t: wait ran out", $time);
		tally_and_finish();
	endtask : lost
	task check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check
	task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			n++;
		end while (!s_axi_bvalid && n < 50);
		s_axi_bready <= 1'b0;
		if (!s_axi_bvalid) lost();
		check(32'(s_axi_bresp), 32'(er));
	endtask : axi_wr
	task axi_rd(input logic [7:0] a);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			n++;
		end while (!s_axi_rvalid && n < 50);
		s_axi_rready <= 1'b0;
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		if (!s_axi_rvalid) lost();
	endtask : axi_rd
	task rd_chk(input logic [7:0] a, input logic [31:0] ex);
		axi_rd(a);
		check(32'(rs), 32'(OK));
		check(rd, ex);
	endtask : rd_chk
	task irq_is(input logic ex);
		@(posedge aclk);
		#1;
		check(32'(irq), 32'(ex));
	endtask : irq_is
	function automatic logic [31:0] sw(input logic [2:0] f, input logic [2:0] n, input logic [4:0] st);
		return (32'(f) << cps_pkg::POS_FAST) | (32'(st) << cps_pkg::POS_ACTIVITY) | 32'(n);
	endfunction : sw

	initial begin
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd_chk(IR, 32'h0);
		rd_chk(IE, 32'h0);
		rd_chk(STW, sw(NC, NC, 5'h00));
		$display("reset test done");
		cps_can_side_i.frame(1'b1, 1'b1);
		rd_chk(STW, sw(NC, NC, 5'h00) | (32'h7 << cps_pkg::POS_ESI));
		rd_chk(STW, sw(NC, NC, 5'h00));
		cps_can_side_i.frame(1'b0, 1'b1);
		rd_chk(STW, sw(NC, NC, 5'h00) | (32'h6 << cps_pkg::POS_ESI));
		$display("esi test done");
		for (int c = 1; c < 7; c++) begin
			cps_can_side_i.bus_event(1'b1, 1'b1, c[2:0]);
			rd_chk(STW, sw(c[2:0], NC, 5'h00));
			cps_can_side_i.bus_event(1'b0, 1'b1, c[2:0]);
			rd_chk(STW, sw(NC, c[2:0], 5'h00));
		end
		cps_can_side_i.bus_event(1'b1, 1'b0, 3'h0);
		rd_chk(STW, sw(3'h0, NC, 5'h00));
		rd_chk(STW, sw(NC, NC, 5'h00));
		$display("error code test done");
		for (int i = 0; i < 6; i++) begin
			cps_can_side_i.set_state(i[0], tecs[i], recs[i], i[1:0]);
			e = sw(NC, NC, {i[0], tecs[i] >= cps_pkg::WARN_LIMIT || recs[i] >= cps_pkg::WARN_LIMIT,
				tecs[i] >= cps_pkg::PASSIVE_LIMIT || recs[i] >= cps_pkg::PASSIVE_LIMIT, i[1:0]});
			rd_chk(STW, e);
			axi_wr(STW, 32'hFFFF_FFFF, OK);
			rd_chk(STW, e);
		end
		$display("state test done");
		axi_wr(IR, 32'h0000_003F, OK);
		rd_chk(IR, 32'h0);
		cps_can_side_i.frame(1'b0, 1'b0);
		irq_is(1'b0);
		rd_chk(IR, 32'h1 << cps_pkg::IRQ_FD);
		axi_wr(IE, 32'h0000_0001, OK);
		rd_chk(IE, 32'h1);
		irq_is(1'b1);
		axi_wr(IR, 32'h0000_0001, OK);
		irq_is(1'b0);
		$display("interrupt test done");
		axi_rd(8'h00);
		check(32'(rs), 32'(cps_pkg::RESP_SLVERR));
		check(rd, 32'h0);
		axi_wr(8'h10, 32'hFFFF_FFFF, cps_pkg::RESP_SLVERR);
		rd_chk(IE, 32'h1);
		$display("unmapped test done");
		tally_and_finish();
	end
endmodule : cps_status_tb

`default_nettype wire
